// >>> rtl/ccmg_top.sv
// Cooling-curve mode gate: holds the mode flag and answers each command.
`timescale 1ns/1ps
module ccmg_top
  import ccmg_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       cmd_valid_in,
  input  wire ccmg_cmd_t  cmd_in,
  output logic            rsp_valid_out,
  output ccmg_rsp_t       rsp_out,
  output logic [7:0]      reply_char_out,
  output logic            mode_out,
  output logic            menu_show_out,
  output logic            run_start_out,
  output logic            general_exec_out
);

  logic      mode_r;
  logic      rsp_valid_r;
  ccmg_rsp_t rsp_r;
  logic [7:0] reply_r;
  logic      start_r;
  logic      gen_r;
  ccmg_rsp_t dec_rsp;
  logic      mode_nxt;
  logic      start_nxt;

  ccmg_decode u_decode (
    .cmd_in        (cmd_in),
    .mode_in       (mode_r),
    .rsp_out       (dec_rsp),
    .mode_nxt_out  (mode_nxt),
    .run_start_out (start_nxt)
  );

  wire gen_nxt = cmd_valid_in && dec_rsp.accepted && (cmd_in.op == CCMG_OP_GENERAL);

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_r      <= CCMG_MODE_RESET;
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
      reply_r     <= 8'h00;
      start_r     <= 1'b0;
      gen_r       <= 1'b0;
    end else begin
      rsp_valid_r <= cmd_valid_in;
      start_r     <= cmd_valid_in && start_nxt;
      gen_r       <= gen_nxt;
      if (cmd_valid_in) begin
        mode_r  <= mode_nxt;
        rsp_r   <= dec_rsp;
        reply_r <= mode_r ? CCMG_REPLY_CCURVE : CCMG_REPLY_NORMAL;
      end
    end
  end

  assign rsp_valid_out    = rsp_valid_r;
  assign rsp_out          = rsp_r;
  assign reply_char_out   = reply_r;
  assign mode_out         = mode_r;
  assign menu_show_out    = mode_r;
  assign run_start_out    = start_r;
  assign general_exec_out = gen_r;

  mode_reset_a: assert property (@(posedge mclk_in) $rose(resetn_in) |-> !mode_r)
    else $error("mode not off after reset");
  sel_write_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    cmd_valid_in && cmd_in.op == CCMG_OP_MODE_SELECT && cmd_in.has_param && !cmd_in.query
    |=> mode_r == $past(cmd_in.param_on))
    else $error("mode select did not take effect");
  query_reply_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    cmd_valid_in |=> reply_char_out == ($past(mode_r) ? 8'h31 : 8'h30))
    else $error("query reply wrong");
  cc_force_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    cmd_valid_in && cmd_in.op == CCMG_OP_CC_OTHER |=> mode_r)
    else $error("cc command did not force mode on");
  gen_block_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    cmd_valid_in && mode_r && cmd_in.op == CCMG_OP_GENERAL
    |=> rsp_out.refused && !general_exec_out && mode_r)
    else $error("general command not refused");
  sequence start_cmd_s;
    cmd_valid_in && cmd_in.op == CCMG_OP_RUN_START && !cmd_in.query && !cmd_in.has_param;
  endsequence
  // The pulse may only stand a second cycle when a new command was taken meanwhile.
  sequence start_pulse_s;
    run_start_out && mode_r && menu_show_out ##1 (!run_start_out || $past(cmd_valid_in));
  endsequence
  start_run_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    start_cmd_s |=> start_pulse_s)
    else $error("start did not launch run");
  start_bad_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    cmd_valid_in && cmd_in.op == CCMG_OP_RUN_START && (cmd_in.query || cmd_in.has_param)
    |=> rsp_out.invalid && !run_start_out && mode_r == $past(mode_r))
    else $error("bad start not rejected");
  mode_hold_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !cmd_valid_in |=> mode_r == $past(mode_r))
    else $error("mode changed without command");

  sequence query_cmd_s;
    cmd_valid_in && cmd_in.op == CCMG_OP_MODE_SELECT && cmd_in.query && !cmd_in.has_param;
  endsequence
  sequence query_answer_s;
    rsp_valid_out && rsp_out.has_reply && rsp_out.reply_bit == $past(mode_r)
      && mode_r == $past(mode_r);
  endsequence
  query_answer_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    query_cmd_s |=> query_answer_s)
    else $error("mode query answer wrong");
  sel_bad_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    cmd_valid_in && cmd_in.op == CCMG_OP_MODE_SELECT && !cmd_in.query && !cmd_in.has_param
    |=> rsp_out.invalid && mode_r == $past(mode_r))
    else $error("bare mode select not rejected");
  gen_exec_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    cmd_valid_in && !mode_r && cmd_in.op == CCMG_OP_GENERAL
    |=> general_exec_out && !rsp_out.refused && !mode_r)
    else $error("general command not executed");
  rsp_pulse_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    rsp_valid_out == $past(cmd_valid_in))
    else $error("response valid not one cycle after command");

endmodule

// >>> rtl/ccmg_pkg.sv
// Package with command codes, carriers and constants for the cooling-curve mode gate.
package ccmg_pkg;

  typedef enum logic [1:0] {
    CCMG_OP_MODE_SELECT = 2'b00,
    CCMG_OP_RUN_START   = 2'b01,
    CCMG_OP_CC_OTHER    = 2'b10,
    CCMG_OP_GENERAL     = 2'b11
  } ccmg_op_t;

  typedef struct packed {
    ccmg_op_t op;
    logic     query;
    logic     has_param;
    logic     param_on;
  } ccmg_cmd_t;

  typedef struct packed {
    logic accepted;
    logic refused;
    logic invalid;
    logic has_reply;
    logic reply_bit;
  } ccmg_rsp_t;

  localparam logic       CCMG_MODE_RESET = 1'b0;
  localparam logic [7:0] CCMG_REPLY_NORMAL = 8'h30;
  localparam logic [7:0] CCMG_REPLY_CCURVE = 8'h31;

endpackage

// >>> rtl/ccmg_decode.sv
// Combinational classifier of one incoming command against the current mode.
`timescale 1ns/1ps
module ccmg_decode
  import ccmg_pkg::*;
(
  input  wire ccmg_cmd_t cmd_in,
  input  wire logic      mode_in,
  output wire ccmg_rsp_t rsp_out,
  output wire logic      mode_nxt_out,
  output wire logic      run_start_out
);

  wire is_sel   = (cmd_in.op == CCMG_OP_MODE_SELECT);
  wire is_start = (cmd_in.op == CCMG_OP_RUN_START);
  wire is_cc    = (cmd_in.op != CCMG_OP_GENERAL);
  wire bad_start = is_start && (cmd_in.query || cmd_in.has_param);
  wire bad_sel   = is_sel && !cmd_in.query && !cmd_in.has_param;
  wire invalid   = bad_start || bad_sel;
  wire refused   = !is_cc && mode_in;
  wire accepted  = !invalid && !refused;
  wire set_sel   = is_sel && !cmd_in.query && cmd_in.has_param;

  assign rsp_out.accepted  = accepted;
  assign rsp_out.refused   = refused;
  assign rsp_out.invalid   = invalid;
  assign rsp_out.has_reply = accepted && is_sel && cmd_in.query;
  assign rsp_out.reply_bit = mode_in;
  assign run_start_out     = accepted && is_start;

  // Explicit select writes the parameter, a select query only reports the mode.
  // Every other accepted cc command forces the mode on.
  assign mode_nxt_out = !accepted          ? mode_in :
                        set_sel            ? cmd_in.param_on :
                        (is_cc && !is_sel) ? 1'b1 :
                                             mode_in;

endmodule

// >>> verification/ccmg_host.sv
// Remote host model that sends one command at a time to the mode gate.
`timescale 1ns/1ps
module ccmg_host
  import ccmg_pkg::*;
(
  input  wire logic mclk_in,
  output logic      cmd_valid_out,
  output ccmg_cmd_t cmd_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end
  // Between commands the fields show the inverse so stale values are never trusted.
  task automatic send(input ccmg_cmd_t c);
    @(posedge mclk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_out = c;
    @(posedge mclk_in);
    #1;
    cmd_valid_out = 1'b0;
    cmd_out = ~c;
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the cooling-curve mode gate.
`timescale 1ns/1ps
module tb_top;
  import ccmg_pkg::*;
  logic mclk_in = 1'b0, resetn_in = 1'b0, cmd_valid, rsp_valid, mode, menu, run, gexec;
  ccmg_cmd_t cmd;
  ccmg_rsp_t rsp;
  logic [7:0] rch;
  int err_total = 0, checked = 0, cycles = 0;
  ccmg_host u_ccmg_host (.mclk_in(mclk_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd));
  ccmg_top u_ccmg_top (.mclk_in(mclk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .rsp_valid_out(rsp_valid), .rsp_out(rsp), .reply_char_out(rch),
    .mode_out(mode), .menu_show_out(menu), .run_start_out(run), .general_exec_out(gexec));
  initial forever #2 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic go(ccmg_op_t op, logic q, logic p, logic on);
    u_ccmg_host.send('{op, q, p, on});
    chk("rsp_valid", rsp_valid, 8'h01);
  endtask
  task automatic t_query(logic m);
    go(CCMG_OP_MODE_SELECT, 1'b1, 1'b0, 1'b0);
    chk("reply", rch, m ? CCMG_REPLY_CCURVE : CCMG_REPLY_NORMAL);
    chk("accepted has_reply reply_bit", {rsp.accepted, rsp.has_reply, rsp.reply_bit},
      {1'b1, 1'b1, m});
    chk("mode", mode, m);
  endtask
  task automatic t_select_bad();
    go(CCMG_OP_MODE_SELECT, 1'b0, 1'b0, 1'b1);
    chk("invalid accepted mode", {rsp.invalid, rsp.accepted, mode}, 8'h04);
  endtask
  task automatic t_reset();
    resetn_in = 1'b0;
    #1;
    chk("mode", mode, CCMG_MODE_RESET);
    @(posedge mclk_in);
    #1;
    resetn_in = 1'b1;
    chk("rsp_valid run exec", {rsp_valid, run, gexec}, 8'h00);
  endtask
  task automatic t_select(logic on);
    go(CCMG_OP_MODE_SELECT, 1'b0, 1'b1, on);
    chk("mode", mode, on);
  endtask
  task automatic t_general(logic m);
    go(CCMG_OP_GENERAL, 1'b0, 1'b0, 1'b0);
    chk("exec", gexec, !m);
    chk("refused", rsp.refused, m);
    chk("mode", mode, m);
  endtask
  task automatic t_other();
    go(CCMG_OP_CC_OTHER, 1'b0, 1'b0, 1'b0);
    chk("mode", mode, 8'h01);
  endtask
  task automatic t_start();
    go(CCMG_OP_RUN_START, 1'b0, 1'b0, 1'b0);
    chk("run", run, 8'h01);
    chk("mode menu", {mode, menu}, 8'h03);
    @(posedge mclk_in);
    #1;
    chk("run", run, 8'h00);
  endtask
  task automatic t_start_bad();
    go(CCMG_OP_RUN_START, 1'b1, 1'b0, 1'b0);
    chk("invalid run mode", {rsp.invalid, run, mode}, 8'h04);
    go(CCMG_OP_RUN_START, 1'b0, 1'b1, 1'b1);
    chk("invalid run mode", {rsp.invalid, run, mode}, 8'h04);
  endtask
  initial begin
    repeat (6) @(posedge mclk_in);
    #1;
    resetn_in = 1'b1;
    chk("mode", mode, CCMG_MODE_RESET);
    t_query(1'b0);
    t_general(1'b0);
    t_other();
    t_query(1'b1);
    t_general(1'b1);
    t_select(1'b0);
    t_general(1'b0);
    t_select(1'b1);
    t_start();
    t_select(1'b0);
    t_start();
    t_reset();
    t_select(1'b0);
    t_select_bad();
    t_start_bad();
    summarize();
  end
endmodule
